/* File: design/strap_peripheral_pin_select.sv */
// The AXI4-Lite register port and the address map were decided locally.
`default_nettype none
module strap_peripheral_pin_select (
	input wire logic aclk,
	input wire logic aresetn,
	// strap pins
	input wire logic atm_port_select_strap,
	input wire logic pci_select_strap,
	input wire logic eeprom_autoinit_strap,
	input wire logic serial_port2_select,
	// peripheral enables
	output logic atm_port_enable,
	output logic buffered_serial_port1_enable,
	output logic host_port_enable,
	output logic pci_enable,
	output logic buffered_serial_port2_enable,
	output logic eeprom_if_enable,
	output logic pci_config_start,
	output logic pci_config_from_eeprom,
	// atm-only and serial-port-1-only pin drive permits
	output logic atm_standalone_drive_en,
	output logic bsp1_standalone_drive_en,
	// upper gpio / pci shared pins
	input wire logic [6:0] upper_gpio_pins_i,
	output logic [6:0] upper_gpio_pins_o,
	output logic [6:0] upper_gpio_pins_oe,
	input wire logic [6:0] pci_shared_o,
	input wire logic [6:0] pci_shared_oe,
	// pci-only pins
	input wire logic pci_byte_enable0_core_o,
	input wire logic pci_byte_enable0_core_oe,
	output logic pci_byte_enable0_pin_o,
	output logic pci_byte_enable0_pin_oe,
	input wire logic serial_eeprom_select_core_o,
	output logic serial_eeprom_select_pin_o,
	output logic serial_eeprom_select_pin_oe,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pin_select_pkg::init_state_e init;
		logic atm;
		logic pci;
		logic autoinit;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [6:0] gpio_en;
		logic [6:0] gpio_dir;
		logic [6:0] gpio_out;
		logic [6:0] gp_o;
		logic [6:0] gp_oe;
		logic be0_o;
		logic be0_oe;
		logic ees_o;
		logic ees_oe;
	} state_s;

	state_s s_q;
	state_s s_d;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] strap_sync;
	logic [6:0] gpio_in_sync;
	logic atm_s;
	logic pci_s;
	logic autoinit_s;
	logic sp2_s;

	level_sync #(
		.width(pin_select_pkg::strap_w + pin_select_pkg::upper_gpio_w)
	) u_sync (
		.aclk(aclk),
		.async_in({upper_gpio_pins_i, serial_port2_select,
			eeprom_autoinit_strap, pci_select_strap,
			atm_port_select_strap}),
		.sync_out({gpio_in_sync, strap_sync})
	);

	assign atm_s = strap_sync[0];
	assign pci_s = strap_sync[1];
	assign autoinit_s = strap_sync[2];
	// port 2 select is used live, not latched
	assign sp2_s = strap_sync[3];

	// ------------------------------------------------------------
	// peripheral ownership
	// ------------------------------------------------------------
	logic eeprom_owns;
	logic [6:0] gpio_drive;

	// serial port 0, timers and the lower gpio pins have no path
	// through this block, so nothing here can take them away
	assign atm_port_enable = s_q.atm;
	assign buffered_serial_port1_enable = ~s_q.atm;
	assign atm_standalone_drive_en = s_q.atm;
	assign bsp1_standalone_drive_en = ~s_q.atm;
	assign host_port_enable = ~s_q.pci;
	assign pci_enable = s_q.pci;
	// the eeprom owns its pins only for pci with port 2 off
	assign eeprom_owns = s_q.pci & ~sp2_s;
	assign buffered_serial_port2_enable = ~eeprom_owns;
	assign eeprom_if_enable = eeprom_owns;
	assign pci_config_start = s_q.pci &&
		(s_q.init == pin_select_pkg::init_config);
	// the source flag is only meaningful alongside the start pulse
	assign pci_config_from_eeprom = pci_config_start & s_q.autoinit &
		~eeprom_owns_at_cfg_n(s_q.init, sp2_s);
	// a gpio pin drives only when enabled and set as output
	assign gpio_drive = s_q.gpio_en & s_q.gpio_dir;

	// port 2 select is sampled at the config step; later changes
	// take the pins back from a started eeprom load; the source is not held
	function automatic logic eeprom_owns_at_cfg_n(
		input pin_select_pkg::init_state_e st,
		input logic sp2
	);
		eeprom_owns_at_cfg_n = (st == pin_select_pkg::init_config)
			? sp2 : 1'b0;
	endfunction : eeprom_owns_at_cfg_n

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign upper_gpio_pins_o = s_q.gp_o;
	assign upper_gpio_pins_oe = s_q.gp_oe;
	assign pci_byte_enable0_pin_o = s_q.be0_o;
	assign pci_byte_enable0_pin_oe = s_q.be0_oe;
	assign serial_eeprom_select_pin_o = s_q.ees_o;
	assign serial_eeprom_select_pin_oe = s_q.ees_oe;
	assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
	assign s_axi_wready = ~s_q.w_held & ~s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	logic [31:0] strap_status_v;
	logic [31:0] periph_status_v;

	always_comb begin
		strap_status_v = 32'h0;
		strap_status_v[pin_select_pkg::st_atm_bit] = s_q.atm;
		strap_status_v[pin_select_pkg::st_pci_bit] = s_q.pci;
		strap_status_v[pin_select_pkg::st_autoinit_bit] = s_q.autoinit;
		strap_status_v[pin_select_pkg::st_sp2_live_bit] = sp2_s;
		strap_status_v[pin_select_pkg::st_ready_bit] =
			(s_q.init == pin_select_pkg::init_run);
		periph_status_v = 32'h0;
		periph_status_v[pin_select_pkg::pe_atm_bit] = atm_port_enable;
		periph_status_v[pin_select_pkg::pe_bsp1_bit] =
			buffered_serial_port1_enable;
		periph_status_v[pin_select_pkg::pe_host_bit] = host_port_enable;
		periph_status_v[pin_select_pkg::pe_pci_bit] = pci_enable;
		periph_status_v[pin_select_pkg::pe_bsp2_bit] =
			buffered_serial_port2_enable;
		periph_status_v[pin_select_pkg::pe_eeprom_bit] = eeprom_if_enable;
		periph_status_v[pin_select_pkg::pe_cfg_eeprom_bit] =
			s_q.pci & s_q.autoinit;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// init sequence: capture straps, start pci config, run
		case (s_q.init)
			pin_select_pkg::init_capture: begin
				// synchronised levels were taken while reset was held
				s_d.atm = atm_s;
				s_d.pci = pci_s;
				s_d.autoinit = autoinit_s;
				s_d.init = pin_select_pkg::init_config;
			end
			pin_select_pkg::init_config: begin
				s_d.init = pin_select_pkg::init_run;
			end
			pin_select_pkg::init_run: begin
				// latched straps are never reloaded here
				s_d.init = pin_select_pkg::init_run;
			end
			default: begin
				s_d.init = pin_select_pkg::init_capture;
			end
		endcase

		// shared gpio/pci pins
		if (s_q.pci) begin
			s_d.gp_o = pci_shared_o;
			s_d.gp_oe = pci_shared_oe;
		end else begin
			s_d.gp_o = s_q.gpio_out;
			s_d.gp_oe = gpio_drive;
		end

		// byte enable 0 floats unless pci owns it, eeprom select unless the eeprom owns it
		s_d.be0_o = s_q.pci & pci_byte_enable0_core_o;
		s_d.be0_oe = s_q.pci & pci_byte_enable0_core_oe;
		s_d.ees_o = eeprom_owns & serial_eeprom_select_core_o;
		s_d.ees_oe = eeprom_owns;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_held && s_q.w_held) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = pin_select_pkg::resp_okay;
			case (s_q.awaddr)
				pin_select_pkg::gpio_enable_off: begin
					if (s_q.wstrb[0]) begin
						s_d.gpio_en = s_q.wdata[6:0];
					end
				end
				pin_select_pkg::gpio_direction_off: begin
					if (s_q.wstrb[0]) begin
						s_d.gpio_dir = s_q.wdata[6:0];
					end
				end
				pin_select_pkg::gpio_out_off: begin
					if (s_q.wstrb[0]) begin
						s_d.gpio_out = s_q.wdata[6:0];
					end
				end
				pin_select_pkg::strap_status_off,
				pin_select_pkg::periph_status_off,
				pin_select_pkg::gpio_in_off: begin
					// read-only: write ignored
					s_d.bresp = pin_select_pkg::resp_okay;
				end
				default: begin
					s_d.bresp = pin_select_pkg::resp_slverr;
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// read channel
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = pin_select_pkg::resp_okay;
			case (s_axi_araddr)
				pin_select_pkg::strap_status_off: begin
					s_d.rdata = strap_status_v;
				end
				pin_select_pkg::periph_status_off: begin
					s_d.rdata = periph_status_v;
				end
				pin_select_pkg::gpio_enable_off: begin
					s_d.rdata = {25'h0, s_q.gpio_en};
				end
				pin_select_pkg::gpio_direction_off: begin
					s_d.rdata = {25'h0, s_q.gpio_dir};
				end
				pin_select_pkg::gpio_out_off: begin
					s_d.rdata = {25'h0, s_q.gpio_out};
				end
				pin_select_pkg::gpio_in_off: begin
					s_d.rdata = {25'h0, gpio_in_sync};
				end
				default: begin
					s_d.rdata = 32'h0;
					s_d.rresp = pin_select_pkg::resp_slverr;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.init <= pin_select_pkg::init_capture;
			s_q.atm <= pin_select_pkg::atm_strap_rst;
			s_q.pci <= pin_select_pkg::pci_strap_rst;
			s_q.autoinit <= pin_select_pkg::autoinit_strap_rst;
			s_q.gpio_en <= pin_select_pkg::gpio_enable_rst;
			s_q.gpio_dir <= pin_select_pkg::gpio_direction_rst;
			s_q.gpio_out <= pin_select_pkg::gpio_out_rst;
		end else begin
			s_q <= s_d;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{s_axi_awprot, s_axi_arprot, s_q.wdata[31:7],
		s_q.wstrb[3:1]};
endmodule : strap_peripheral_pin_select
`default_nettype wire

/* File: design/pin_select_pkg.sv */
`default_nettype none
package pin_select_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] strap_status_off = 8'h00;
	localparam logic [7:0] periph_status_off = 8'h04;
	localparam logic [7:0] gpio_enable_off = 8'h08;
	localparam logic [7:0] gpio_direction_off = 8'h0c;
	localparam logic [7:0] gpio_out_off = 8'h10;
	localparam logic [7:0] gpio_in_off = 8'h14;
	localparam int addr_w = 8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int st_atm_bit = 0;
	localparam int st_pci_bit = 1;
	localparam int st_autoinit_bit = 2;
	localparam int st_sp2_live_bit = 3;
	localparam int st_ready_bit = 4;
	localparam int pe_atm_bit = 0;
	localparam int pe_bsp1_bit = 1;
	localparam int pe_host_bit = 2;
	localparam int pe_pci_bit = 3;
	localparam int pe_bsp2_bit = 4;
	localparam int pe_eeprom_bit = 5;
	localparam int pe_cfg_eeprom_bit = 6;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int upper_gpio_w = 7;
	localparam int strap_w = 4;
	localparam int sync_stages = 2;
	localparam logic [6:0] gpio_enable_rst = 7'h00;
	localparam logic [6:0] gpio_direction_rst = 7'h00;
	localparam logic [6:0] gpio_out_rst = 7'h00;
	// default strap levels: serial port 1 and host port own the pins
	localparam logic atm_strap_rst = 1'b0;
	localparam logic pci_strap_rst = 1'b0;
	localparam logic autoinit_strap_rst = 1'b0;

	// ------------------------------------------------------------
	// bus answers and init sequence
	// ------------------------------------------------------------
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [1:0] {
		init_capture = 2'b00,
		init_config = 2'b01,
		init_run = 2'b11
	} init_state_e;
endpackage : pin_select_pkg
`default_nettype wire

/* File: design/level_sync.sv */
`default_nettype none
// two-stage synchroniser per bit; no reset so that the pins are still
// tracked while the device sits in reset
module level_sync #(
	parameter int width = 1
) (
	input wire logic aclk,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] meta_q;
	logic [width-1:0] stable_q;

	genvar i;
	generate
		for (i = 0; i < width; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				meta_q[i] <= async_in[i];
				stable_q[i] <= meta_q[i];
			end
		end
	endgenerate

	assign sync_out = stable_q;
endmodule : level_sync
`default_nettype wire

/* File: sim/strap_board.sv */
`default_nettype none
// ------------------------------------------------------------
// board strap resistors
// ------------------------------------------------------------
// a resistor always gives a valid level; wild lets each loop scenario move
// the reset-only straps while the device runs
module strap_board (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wild,
	input wire logic [3:0] want,
	output var logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins = 4'h0;
	always @(posedge aclk) begin
		if (!aresetn || wild) begin
			pins[2:0] <= want[2:0];
		end
		pins[3] <= want[3];
	end
endmodule : strap_board
`default_nettype wire

/* File: sim/strap_peripheral_pin_select_chk.sv */
`default_nettype none
module strap_peripheral_pin_select_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic serial_port2_select,
	input wire logic atm_port_enable,
	input wire logic buffered_serial_port1_enable,
	input wire logic host_port_enable,
	input wire logic pci_enable,
	input wire logic buffered_serial_port2_enable,
	input wire logic eeprom_if_enable,
	input wire logic pci_config_start,
	input wire logic pci_config_from_eeprom,
	input wire logic atm_standalone_drive_en,
	input wire logic bsp1_standalone_drive_en,
	input wire logic [6:0] upper_gpio_pins_oe,
	input wire logic [6:0] pci_shared_oe,
	input wire logic pci_byte_enable0_core_oe,
	input wire logic pci_byte_enable0_pin_oe,
	input wire logic serial_eeprom_select_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// ownership checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_atm_excl: assert property (
		atm_port_enable != buffered_serial_port1_enable)
		else $error("atm and port1 overlap");
	a_host_excl: assert property (
		host_port_enable != pci_enable)
		else $error("host and pci overlap");
	a_bsp2_live: assert property (
		buffered_serial_port2_enable == !(pci_enable &&
		!$past(serial_port2_select, 2)) &&
		eeprom_if_enable != buffered_serial_port2_enable)
		else $error("port2 select wrong");
	// the latch may land on either of the first two edges after release
	a_latch_hold: assert property (
		$past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn) |->
		$stable(pci_enable) && $stable(atm_port_enable))
		else $error("latched strap moved");
	a_pci_own: assert property (
		pci_enable ##1 pci_enable |->
		upper_gpio_pins_oe == $past(pci_shared_oe) &&
		pci_byte_enable0_pin_oe == $past(pci_byte_enable0_core_oe))
		else $error("pci lost shared pins");
	a_pins_hiz: assert property (
		!pci_enable ##1 !pci_enable |-> !pci_byte_enable0_pin_oe)
		else $error("pci pin driven");
	a_eeprom_oe: assert property (
		$past(aresetn) |->
		serial_eeprom_select_pin_oe == $past(eeprom_if_enable))
		else $error("eeprom select drive wrong");
	a_cfg_pulse: assert property (
		pci_config_start |=> !pci_config_start)
		else $error("config start too long");
	a_cfg_source: assert property (
		pci_config_from_eeprom |-> pci_config_start && eeprom_if_enable)
		else $error("eeprom source wrong");
	a_atm_float: assert property (
		!atm_port_enable ##1 !atm_port_enable |-> !atm_standalone_drive_en)
		else $error("atm pins driven");
	a_bsp1_float: assert property (
		atm_port_enable ##1 atm_port_enable |-> !bsp1_standalone_drive_en)
		else $error("port1 pins driven");
endmodule : strap_peripheral_pin_select_chk
bind strap_peripheral_pin_select strap_peripheral_pin_select_chk chk_u (.*);
`default_nettype wire

/* File: sim/strap_peripheral_pin_select_test.sv */
`default_nettype none
module strap_peripheral_pin_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, wild = 1'b0, from_ee = 1'b0;
	logic [3:0] want = 4'h0, pins;
	logic [6:0] upper_gpio_pins_i = 7'h2a, pci_shared_o = 7'h33;
	logic [6:0] pci_shared_oe = 7'h4c, upper_gpio_pins_o, upper_gpio_pins_oe;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic atm_port_enable, buffered_serial_port1_enable, host_port_enable;
	logic pci_enable, buffered_serial_port2_enable, eeprom_if_enable;
	logic pci_config_start, pci_config_from_eeprom;
	logic atm_standalone_drive_en, bsp1_standalone_drive_en;
	logic pci_byte_enable0_pin_o, pci_byte_enable0_pin_oe;
	logic serial_eeprom_select_pin_o, serial_eeprom_select_pin_oe;
	int n_mismatch = 0, total_checks = 0, n_start = 0;
	strap_board board_u (.aclk, .aresetn, .wild, .want, .pins);
	strap_peripheral_pin_select dut_u (.*,
		.atm_port_select_strap(pins[0]), .pci_select_strap(pins[1]),
		.eeprom_autoinit_strap(pins[2]), .serial_port2_select(pins[3]),
		.pci_byte_enable0_core_o(pci_shared_o[1]),
		.pci_byte_enable0_core_oe(pci_shared_oe[2]),
		.serial_eeprom_select_core_o(pci_shared_o[0]),
		.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf));
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		if (aresetn && pci_config_start) begin
			n_start++;
			from_ee = pci_config_from_eeprom;
		end
	end
	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(inout int n);
		@(posedge aclk);
		if (++n > 50) begin
			n_mismatch++;
			give_verdict();
		end
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] dt,
		output logic [1:0] r);
		logic aw, w;
		int n;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			tick(n);
			if (s_axi_bvalid) break;
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] dt,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			tick(n);
			if (s_axi_rvalid) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		dt = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// straps are {port2 select, autoinit, pci, atm}
	task automatic boot(input logic [3:0] v);
		@(posedge aclk);
		aresetn <= 1'b0;
		want <= v;
		n_start = 0;
		from_ee = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
	endtask : boot
	task automatic cfg(input logic [3:0] v);
		logic x;
		logic [5:0] en;
		logic [31:0] d;
		logic [1:0] r;
		x = v[1] & !v[3];
		en = {x, !x, v[1], !v[1], !v[0], v[0]};
		chk("enables", {26'h0, en}, {26'h0, eeprom_if_enable,
			buffered_serial_port2_enable, pci_enable, host_port_enable,
			buffered_serial_port1_enable, atm_port_enable});
		chk("drive", {30'h0, !v[0], v[0]}, {30'h0,
			bsp1_standalone_drive_en, atm_standalone_drive_en});
		chk("pin_oe", {30'h0, x, v[1]}, {30'h0,
			serial_eeprom_select_pin_oe, pci_byte_enable0_pin_oe});
		chk("pin_o", {30'h0, x & pci_shared_o[0],
			v[1] & pci_shared_o[1]}, {30'h0, serial_eeprom_select_pin_o,
			pci_byte_enable0_pin_o});
		rd(8'h00, d, r);
		chk("strap_st", {27'h1, v}, d);
		rd(8'h04, d, r);
		chk("periph_st", {25'h0, v[1] & v[2], en}, d);
	endtask : cfg
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [3:0] v;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 16; i++) begin
			// the autoinit strap is only pulled up on pci boards
			v = {i[3], i[2] & i[1], i[1], i[0]};
			boot(v);
			chk("cfg_start", {31'h0, v[1]}, 32'(n_start));
			chk("cfg_src", {31'h0, v[1] & v[2] & !v[3]}, {31'h0, from_ee});
			cfg(v);
			wild <= 1'b1;
			want <= {1'b1, ~v[2:0]};
			repeat (6) @(posedge aclk);
			cfg({1'b1, v[2:0]});
			wild <= 1'b0;
		end
		boot(4'h0);
		wr(8'h08, 32'h7f, r);
		wr(8'h0c, 32'h0f, r);
		wr(8'h10, 32'h55, r);
		repeat (2) @(posedge aclk);
		chk("gpio_oe", 32'h0f, {25'h0, upper_gpio_pins_oe});
		chk("gpio_o", 32'h55, {25'h0, upper_gpio_pins_o});
		rd(8'h08, d, r);
		chk("gpio_en", 32'h7f, d);
		wr(8'h14, 32'h0, r);
		chk("ro_resp", {30'h0, pin_select_pkg::resp_okay}, {30'h0, r});
		rd(8'h14, d, r);
		chk("gpio_in", 32'h2a, d);
		rd(8'h20, d, r);
		chk("bad_resp", {30'h0, pin_select_pkg::resp_slverr}, {30'h0, r});
		chk("bad_data", 32'h0, d);
		boot(4'h2);
		wr(8'h08, 32'h7f, r);
		wr(8'h0c, 32'h7f, r);
		pci_shared_o <= 7'h5a;
		repeat (2) @(posedge aclk);
		chk("shared_o", 32'h5a, {25'h0, upper_gpio_pins_o});
		chk("shared_oe", 32'h4c, {25'h0, upper_gpio_pins_oe});
		give_verdict();
	end
endmodule : strap_peripheral_pin_select_test
`default_nettype wire
